// ---- rtl/msi_status_map.svh ----
/*
 * Offsets, bit positions, reset values and timing counts of the modem
 * status and interrupt block.
 * Assumes inclusion by bare name from package or module files.
 */
`ifndef MSI_STATUS_MAP_SVH
`define MSI_STATUS_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MSI_STATUS_ADDR 8'hE6
`define MSI_STATUS_RESET 16'h0000
`define MSI_ADDR_BITS 8
`define MSI_DATA_BITS 16

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define MSI_B_IRQ 15
`define MSI_B_RING 14
`define MSI_B_PROG 13
`define MSI_B_TXRDY 12
`define MSI_B_TXUF 11

// ----------------------------------------------------------------
// interrupt mask positions in the control word
// ----------------------------------------------------------------
`define MSI_M_RING 5
`define MSI_M_PROG 4
`define MSI_M_TX 3
`define MSI_M_B10 2
`define MSI_M_B9_7 1
`define MSI_M_B6_5 0

// ----------------------------------------------------------------
// received key codes
// ----------------------------------------------------------------
`define MSI_DTMF_ZERO 4'hA
`define MSI_DTMF_STAR 4'hB
`define MSI_DTMF_HASH 4'hC
`define MSI_DTMF_A 4'hD
`define MSI_DTMF_D 4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MSI_CLK_MHZ 100
`define MSI_SETTLE_US 150
`define MSI_SETTLE_CYC (`MSI_SETTLE_US * `MSI_CLK_MHZ)

`endif

// ---- rtl/msi_pkg.sv ----
/*
 * Types shared by the modem status and interrupt block.
 * Assumes nothing of its surroundings.
 */
package msi_pkg;

  // receive operating mode
  typedef enum logic [1:0] {
    MSI_RX_TONES,
    MSI_RX_FSK,
    MSI_RX_MANUAL,
    MSI_RX_QAM_AUTO
  } msi_rxmode_t;

  // serial link frame phase
  typedef enum logic [1:0] {
    MSI_SH_ADDR,
    MSI_SH_DATA,
    MSI_SH_DONE
  } msi_shstate_t;

endpackage

// ---- rtl/msi_sync2.sv ----
/*
 * Two flip-flop level synchroniser, one per bit.
 * Assumes d comes from another clock domain or a pin.
 */
`timescale 1ns/1ns
module msi_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q <= RST;
    end else if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- rtl/msi_status_irq.sv ----
/*
 * Status word and interrupt logic of a line modem, with the serial
 * status read port on its own link clock.
 * Assumes detector and data path inputs are on CLK; ring sense and
 * the serial link pins are asynchronous.
 */
`timescale 1ns/1ns
`include "msi_status_map.svh"
module msi_status_irq #(
  parameter int SETTLE_CYC = `MSI_SETTLE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // serial link
  input wire logic SER_CLK,
  input wire logic SER_CS_N,
  input wire logic SER_CMD,
  output logic SER_REPLY,
  output logic SER_REPLY_OE,
  // general control
  input wire logic [5:0] CTL_IRQ_MASK,
  input wire logic CTL_PIN_EN,
  input wire logic CTL_RESET,
  input wire logic CTL_POWERUP,
  input wire logic GEN_RESET,
  // pins
  input wire logic RING_SENSE_IN_N,
  output logic INTERRUPT_OUT_N,
  // transmit and programming
  input wire logic TX_READY_EVT,
  input wire logic TX_UNDERFLOW_EVT,
  input wire logic TX_DATA_WR,
  input wire logic PROG_WR,
  input wire logic PROG_DONE,
  // receive mode and tone detectors
  input wire msi_pkg::msi_rxmode_t RX_MODE,
  input wire logic DESCR_EN,
  input wire logic HDLC_MODE,
  input wire logic TONE_CP_ENERGY,
  input wire logic TONE_PAIR,
  input wire logic TONE_2100_OR_T2,
  input wire logic TONE_2225_OR_T1,
  input wire logic DTMF_VALID,
  input wire logic [3:0] DTMF_KEY,
  // pattern detectors
  input wire logic RX_ENERGY,
  input wire logic SYNC_PATTERN,
  input wire logic CONT_ZEROS_UNSCR,
  input wire logic CONT_ONES_UNSCR,
  input wire logic CONT_ZEROS_SCR,
  input wire logic CONT_ONES_SCR,
  // automodem
  input wire logic QAM_EVENT,
  input wire logic QAM_STATUS_RD,
  input wire logic BREAK_DET,
  // receive data path
  input wire logic RX_READY_EVT,
  input wire logic RX_OVERFLOW_EVT,
  input wire logic RX_DATA_RD,
  input wire logic FRAMING_ERR_EVT,
  input wire logic PARITY_EVEN_1,
  input wire logic PARITY_EVEN_2,
  input wire logic FCS_LAST,
  input wire logic TWO_CHARS,
  input wire logic DEMOD_BIT,
  input wire logic DEMOD_STROBE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ring_s, cs_s, cs_prev_r, rd_tgl_s, rd_prev_r, rd_tgl_r;
  logic frame_start, status_rd, clr_all, pwr_prev_r, hard_clr;
  logic tx_rdy_r, tx_uf_r, prog_r, qam_ev_r, brk_r;
  logic rx_rdy_r, rx_ov_r, fr_err_r, demod_r, irq_r, irq_late_r;
  logic irq_set, irq_n_r, settle_busy, tones, qam;
  logic [3:0] dtmf_code_r;
  logic [14:0] stat_r, stat_nxt;
  logic [14:5] rise, mask;
  logic [15:0] held_r, sh_r, settle_cnt_r;
  logic [7:0] addr_r, addr_nxt;
  logic [4:0] bit_cnt_r;
  logic ser_rst_n;
  msi_pkg::msi_rxmode_t mode_prev_r;
  msi_pkg::msi_shstate_t sh_state_r;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  msi_sync2 #(.W(3), .RST(3'b110)) u_sync (
    .clk(CLK),
    .rst_n(RESET_N),
    .en(CE),
    .d({RING_SENSE_IN_N, SER_CS_N, rd_tgl_r}),
    .q({ring_s, cs_s, rd_tgl_s})
  );

  assign frame_start = cs_prev_r & ~cs_s;
  assign status_rd = rd_tgl_s ^ rd_prev_r;
  assign clr_all = GEN_RESET | CTL_RESET | ~CTL_POWERUP;
  assign hard_clr = GEN_RESET | CTL_RESET | (CTL_POWERUP & ~pwr_prev_r);
  assign tones = (RX_MODE == msi_pkg::MSI_RX_TONES);
  assign qam = (RX_MODE == msi_pkg::MSI_RX_QAM_AUTO);
  assign settle_busy = (settle_cnt_r != 16'h0000);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_prev_r <= 1'b1;
      rd_prev_r <= 1'b0;
      pwr_prev_r <= 1'b0;
    end else if (CE) begin
      cs_prev_r <= cs_s;
      rd_prev_r <= rd_tgl_s;
      pwr_prev_r <= CTL_POWERUP;
    end
  end

  // ----------------------------------------------------------------
  // key code encoding: key 0-9 digits, 10 star, 11 hash, 12-15 A-D
  // ----------------------------------------------------------------
  function automatic logic [3:0] key_code(input logic [3:0] key);
    logic [3:0] c;
    c = key;
    case (key)
      4'h0: c = `MSI_DTMF_ZERO;
      4'hA: c = `MSI_DTMF_STAR;
      4'hB: c = `MSI_DTMF_HASH;
      4'hC: c = `MSI_DTMF_A;
      4'hD: c = 4'(`MSI_DTMF_A + 4'h1);
      4'hE: c = 4'(`MSI_DTMF_A + 4'h2);
      4'hF: c = `MSI_DTMF_D;
      default: c = key;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // mode change settling
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_prev_r <= msi_pkg::MSI_RX_TONES;
      settle_cnt_r <= 16'h0000;
    end else if (CE) begin
      mode_prev_r <= RX_MODE;
      if (RX_MODE != mode_prev_r)
        settle_cnt_r <= 16'(SETTLE_CYC - 1);
      else if (settle_busy)
        settle_cnt_r <= settle_cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sticky event flags, set wins over read and write clears but loses to clr_all
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_rdy_r <= 1'b0;
      tx_uf_r <= 1'b0;
      prog_r <= 1'b0;
    end else if (CE) begin
      if (clr_all) begin
        tx_rdy_r <= 1'b0;
        tx_uf_r <= 1'b0;
        prog_r <= 1'b0;
      end else begin
        tx_rdy_r <= TX_READY_EVT | (tx_rdy_r & ~TX_DATA_WR);
        tx_uf_r <= TX_UNDERFLOW_EVT | (tx_uf_r & ~TX_DATA_WR);
        prog_r <= PROG_DONE | (prog_r & ~PROG_WR);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      qam_ev_r <= 1'b0;
      brk_r <= 1'b0;
      rx_rdy_r <= 1'b0;
      rx_ov_r <= 1'b0;
      fr_err_r <= 1'b0;
    end else if (CE) begin
      if (clr_all) begin
        qam_ev_r <= 1'b0;
        brk_r <= 1'b0;
        rx_rdy_r <= 1'b0;
        rx_ov_r <= 1'b0;
        fr_err_r <= 1'b0;
      end else begin
        qam_ev_r <= QAM_EVENT | (qam_ev_r & ~QAM_STATUS_RD);
        brk_r <= BREAK_DET | (brk_r & ~(status_rd & held_r[8]));
        rx_rdy_r <= RX_READY_EVT | (rx_rdy_r & ~RX_DATA_RD);
        rx_ov_r <= RX_OVERFLOW_EVT | (rx_ov_r & ~RX_DATA_RD);
        fr_err_r <= FRAMING_ERR_EVT | (fr_err_r & ~(status_rd & held_r[4]));
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dtmf_code_r <= 4'h0;
      demod_r <= 1'b0;
    end else if (CE) begin
      if (clr_all)
        dtmf_code_r <= 4'h0;
      else if (DTMF_VALID)
        dtmf_code_r <= key_code(DTMF_KEY);
      if (clr_all)
        demod_r <= 1'b0;
      else if (DEMOD_STROBE)
        demod_r <= DEMOD_BIT;
    end
  end

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  always_comb begin
    stat_nxt = 15'h0000;
    stat_nxt[`MSI_B_RING] = ~ring_s;
    stat_nxt[`MSI_B_PROG] = prog_r;
    stat_nxt[`MSI_B_TXRDY] = tx_rdy_r;
    stat_nxt[`MSI_B_TXUF] = tx_uf_r;
    case (RX_MODE)
      msi_pkg::MSI_RX_TONES: begin
        stat_nxt[10] = TONE_CP_ENERGY | TONE_PAIR;
        stat_nxt[7] = TONE_2100_OR_T2;
        stat_nxt[6] = TONE_2225_OR_T1;
        stat_nxt[5] = DTMF_VALID;
        stat_nxt[3:0] = dtmf_code_r;
      end
      msi_pkg::MSI_RX_FSK, msi_pkg::MSI_RX_MANUAL: begin
        stat_nxt[10] = RX_ENERGY;
        stat_nxt[9] = SYNC_PATTERN;
        if (DESCR_EN && RX_MODE == msi_pkg::MSI_RX_MANUAL) begin
          if (CONT_ONES_UNSCR)
            stat_nxt[8:7] = 2'b01;
          else if (CONT_ONES_SCR)
            stat_nxt[8:7] = 2'b11;
          else if (CONT_ZEROS_SCR)
            stat_nxt[8:7] = 2'b10;
        end else begin
          if (CONT_ZEROS_UNSCR)
            stat_nxt[8:7] = 2'b10;
          else if (CONT_ONES_UNSCR)
            stat_nxt[8:7] = 2'b01;
        end
        stat_nxt[0] = demod_r;
      end
      msi_pkg::MSI_RX_QAM_AUTO: begin
        stat_nxt[9] = qam_ev_r;
        stat_nxt[8] = brk_r;
      end
      default: stat_nxt[10:7] = 4'h0;
    endcase
    if (!tones) begin
      stat_nxt[6] = rx_rdy_r;
      stat_nxt[5] = rx_ov_r;
      stat_nxt[4] = fr_err_r;
      stat_nxt[3] = HDLC_MODE ? FCS_LAST : PARITY_EVEN_1;
      stat_nxt[2] = ~HDLC_MODE & PARITY_EVEN_2;
      stat_nxt[1] = TWO_CHARS;
    end
    if (settle_busy || RX_MODE != mode_prev_r)
      stat_nxt[10:0] = 11'h000;
    if (clr_all)
      stat_nxt[13:0] = 14'h0000;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      stat_r <= 15'h0000;
    else if (CE)
      stat_r <= stat_nxt;
  end

  // ----------------------------------------------------------------
  // interrupt bit and pin
  // ----------------------------------------------------------------
  assign mask = {CTL_IRQ_MASK[`MSI_M_RING] & CTL_PIN_EN,
                 CTL_IRQ_MASK[`MSI_M_PROG],
                 {2{CTL_IRQ_MASK[`MSI_M_TX]}},
                 CTL_IRQ_MASK[`MSI_M_B10],
                 {3{CTL_IRQ_MASK[`MSI_M_B9_7]}},
                 {2{CTL_IRQ_MASK[`MSI_M_B6_5]}}};
  assign rise = stat_nxt[14:5] & ~stat_r[14:5];
  assign irq_set = |(rise & mask);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_r <= 1'b0;
      irq_late_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else if (CE) begin
      if (hard_clr)
        irq_r <= 1'b0;
      else if (irq_set)
        irq_r <= 1'b1;
      else if (status_rd && !irq_late_r)
        irq_r <= 1'b0;
      if (frame_start || hard_clr)
        irq_late_r <= 1'b0;
      else if (irq_set)
        irq_late_r <= 1'b1;
      irq_n_r <= ~(irq_r & CTL_PIN_EN);
    end
  end

  assign INTERRUPT_OUT_N = irq_n_r;

  // snapshot for the link, steady for the rest of the frame
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      held_r <= `MSI_STATUS_RESET;
    else if (CE && frame_start)
      held_r <= {irq_r, stat_r};
  end

  // ----------------------------------------------------------------
  // serial link, on its own clock
  // ----------------------------------------------------------------
  assign ser_rst_n = RESET_N & ~SER_CS_N;
  assign addr_nxt = {addr_r[6:0], SER_CMD};

  always_ff @(posedge SER_CLK or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      sh_state_r <= msi_pkg::MSI_SH_ADDR;
      bit_cnt_r <= 5'h00;
      addr_r <= 8'h00;
      sh_r <= 16'h0000;
    end else begin
      case (sh_state_r)
        msi_pkg::MSI_SH_ADDR: begin
          addr_r <= addr_nxt;
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'(`MSI_ADDR_BITS - 1)) begin
            bit_cnt_r <= 5'h00;
            if (addr_nxt == `MSI_STATUS_ADDR) begin
              sh_r <= held_r;
              sh_state_r <= msi_pkg::MSI_SH_DATA;
            end else begin
              sh_state_r <= msi_pkg::MSI_SH_DONE;
            end
          end
        end
        msi_pkg::MSI_SH_DATA: begin
          sh_r <= {sh_r[14:0], 1'b0};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'(`MSI_DATA_BITS - 1))
            sh_state_r <= msi_pkg::MSI_SH_DONE;
        end
        default: sh_state_r <= msi_pkg::MSI_SH_DONE;
      endcase
    end
  end

  // read event toggle survives between frames
  always_ff @(posedge SER_CLK or negedge RESET_N) begin
    if (!RESET_N)
      rd_tgl_r <= 1'b0;
    else if (!SER_CS_N && sh_state_r == msi_pkg::MSI_SH_ADDR &&
             bit_cnt_r == 5'(`MSI_ADDR_BITS - 1) && addr_nxt == `MSI_STATUS_ADDR)
      rd_tgl_r <= ~rd_tgl_r;
  end

  assign SER_REPLY = sh_r[15];
  assign SER_REPLY_OE = (sh_state_r == msi_pkg::MSI_SH_DATA);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_clear_all;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && clr_all) |=> (stat_r[13:0] == 14'h0000);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("status not cleared");

  property p_tx_clear;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && TX_DATA_WR && !TX_READY_EVT) |=> !tx_rdy_r;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx ready not cleared");

  property p_tone_zero;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && tones && !settle_busy) |=> (stat_r[9:8] == 2'b00 && !stat_r[4]);
  endproperty
  a_tone_zero: assert property (p_tone_zero) else $error("tone mode bits nonzero");

  property p_key_code;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && !clr_all && DTMF_VALID && DTMF_KEY == 4'h0) |=> (dtmf_code_r == 4'hA);
  endproperty
  a_key_code: assert property (p_key_code) else $error("wrong zero key code");

  property p_inhibit;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && CONT_ONES_UNSCR && !clr_all) |=> (stat_r[8:7] != 2'b11);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("scrambled ones not inhibited");

  property p_rx_clear;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && RX_DATA_RD && !RX_READY_EVT) |=> !rx_rdy_r;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx ready not cleared");

  property p_irq_set;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && irq_set && !hard_clr) |=> irq_r;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("masked edge lost");

  property p_irq_hard_clr;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && (GEN_RESET || CTL_RESET)) |=> !irq_r;
  endproperty
  a_irq_hard_clr: assert property (p_irq_hard_clr) else $error("irq not cleared");

  property p_pin;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && irq_r && CTL_PIN_EN) |=> !INTERRUPT_OUT_N;
  endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin not low");

  property p_settle;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && RX_MODE != mode_prev_r) |=> (stat_r[10:0] == 11'h000);
  endproperty
  a_settle: assert property (p_settle) else $error("mode change not settled");

  property p_qam_zero;
    @(posedge CLK) disable iff (!RESET_N)
    (CE && qam) |=> (stat_r[10] == 1'b0 && stat_r[7] == 1'b0 && stat_r[0] == 1'b0);
  endproperty
  a_qam_zero: assert property (p_qam_zero) else $error("qam mode bits nonzero");

  c_irq_pin: cover property (@(posedge CLK) disable iff (!RESET_N) !INTERRUPT_OUT_N);
  c_status_rd: cover property (@(posedge CLK) disable iff (!RESET_N) status_rd && irq_r);
  c_reply: cover property (@(posedge SER_CLK) disable iff (!RESET_N) SER_REPLY_OE);

endmodule

// ---- verification/msi_host_model.sv ----
/*
 * Host side of the serial status link: makes frames of 8 address bits out
 * and 16 reply bits in, with a link clock of 32 ns that stands still between frames.
 * Assumes the block answers as its link contract describes.
 */
`timescale 1ns/1ns
module msi_host_model (
  // link pins
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_cmd,
  input wire logic ser_reply,
  input wire logic ser_reply_oe
);
  initial begin
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_cmd = 1'b0;
  end

  // ----------------------------------------------------------------
  // one read frame; ok stays 1 only if every reply bit was driven
  // ----------------------------------------------------------------
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    int i;
    data = 16'h0000;
    ok = 1'b1;
    ser_cs_n = 1'b0;
    #60;
    for (i = 0; i < 24; i++) begin
      // past the address the command line toggles, never holding a stale bit
      ser_cmd = (i < 8) ? addr[7 - i] : ~ser_cmd;
      #16 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
      if (i >= 7 && i < 23) begin
        data = {data[14:0], ser_reply};
        ok = ok & (ser_reply_oe === 1'b1);
      end
    end
    #16 ser_cs_n = 1'b1;
    #60;
  endtask
endmodule

// ---- verification/msi_status_irq_tb.sv ----
/*
 * Self-checking bench of the status and interrupt block: events are driven
 * on the falling clock edge and the status word is read over the serial link.
 * Assumes the host model of its own file and a settle count of 20 cycles.
 */
`timescale 1ns/1ns
module msi_status_irq_tb;
  logic clk, reset_n, ce, pin_en, ctl_reset, powerup, gen_reset, ring_n, irq_n;
  logic tx_rdy, tx_uf, tx_wr, prog_wr, prog_done, descr_en, hdlc, cp_en, pair, t2100, t2225;
  logic dtmf_ok, rx_en, sync_p, zu, ou, zs, os, qam_evt, qam_rd, brk, rx_rdy, rx_ovf, rx_rd;
  logic frm, par1, par2, fcs, two, dbit, dstb, sclk, scs_n, scmd, srep, srep_oe;
  logic [5:0] mask;
  logic [3:0] key;
  msi_pkg::msi_rxmode_t mode;
  int err_total;
  int total_checks;
  int cycles;
  int k;

  msi_host_model i_host (.ser_clk(sclk), .ser_cs_n(scs_n), .ser_cmd(scmd), .ser_reply(srep),
    .ser_reply_oe(srep_oe));

  msi_status_irq #(.SETTLE_CYC(20)) i_dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .SER_CLK(sclk),
    .SER_CS_N(scs_n), .SER_CMD(scmd), .SER_REPLY(srep), .SER_REPLY_OE(srep_oe), .CTL_IRQ_MASK(mask),
    .CTL_PIN_EN(pin_en), .CTL_RESET(ctl_reset), .CTL_POWERUP(powerup), .GEN_RESET(gen_reset),
    .RING_SENSE_IN_N(ring_n), .INTERRUPT_OUT_N(irq_n), .TX_READY_EVT(tx_rdy), .TX_UNDERFLOW_EVT(tx_uf),
    .TX_DATA_WR(tx_wr), .PROG_WR(prog_wr), .PROG_DONE(prog_done), .RX_MODE(mode), .DESCR_EN(descr_en),
    .HDLC_MODE(hdlc), .TONE_CP_ENERGY(cp_en), .TONE_PAIR(pair), .TONE_2100_OR_T2(t2100),
    .TONE_2225_OR_T1(t2225), .DTMF_VALID(dtmf_ok), .DTMF_KEY(key), .RX_ENERGY(rx_en),
    .SYNC_PATTERN(sync_p), .CONT_ZEROS_UNSCR(zu), .CONT_ONES_UNSCR(ou), .CONT_ZEROS_SCR(zs),
    .CONT_ONES_SCR(os), .QAM_EVENT(qam_evt), .QAM_STATUS_RD(qam_rd), .BREAK_DET(brk),
    .RX_READY_EVT(rx_rdy), .RX_OVERFLOW_EVT(rx_ovf), .RX_DATA_RD(rx_rd), .FRAMING_ERR_EVT(frm),
    .PARITY_EVEN_1(par1), .PARITY_EVEN_2(par2), .FCS_LAST(fcs), .TWO_CHARS(two), .DEMOD_BIT(dbit),
    .DEMOD_STROBE(dstb));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic rd(input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_host.read_reg(8'hE6, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, exp);
    @(negedge clk);
  endtask

  task automatic pin(input logic exp);
    check({15'h0000, irq_n}, {15'h0000, exp});
  endtask

  // keypad index 0 is digit 0, 10 star, 11 hash, 12 to 15 are A to D
  function automatic logic [3:0] key_code(input int n);
    if (n == 0)
      return 4'hA;
    if (n < 10)
      return n[3:0];
    if (n < 15)
      return n[3:0] + 4'h1;
    return 4'h0;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic ok;
    {clk, reset_n, pin_en, ctl_reset, gen_reset, tx_rdy, tx_uf, tx_wr, prog_wr, prog_done, descr_en} = '0;
    {hdlc, cp_en, pair, t2100, t2225, dtmf_ok, rx_en, sync_p, zu, ou, zs, os, qam_evt, qam_rd} = '0;
    {brk, rx_rdy, rx_ovf, rx_rd, frm, par1, par2, fcs, two, dbit, dstb, mask} = '0;
    {err_total, total_checks, cycles} = '0;
    mode = msi_pkg::MSI_RX_TONES;
    ce = 1'b1;
    powerup = 1'b1;
    ring_n = 1'b1;
    key = 4'hF;
    cyc(3);
    reset_n = 1'b1;
    cyc(30);
    rd(16'h0000);
    i_host.read_reg(8'h55, d, ok);
    check({15'h0000, ok}, 16'h0000);
    pulse(prog_done);
    cyc(2);
    rd(16'h2000);
    pulse(prog_wr);
    cyc(2);
    rd(16'h0000);
    mask = 6'h08;
    pin_en = 1'b1;
    pulse(tx_rdy);
    cyc(3);
    pin(1'b0);
    rd(16'h9000);
    cyc(8);
    pin(1'b1);
    pulse(tx_uf);
    cyc(3);
    rd(16'h9800);
    pulse(tx_wr);
    cyc(3);
    rd(16'h0000);
    for (k = 0; k < 3; k++) begin
      pulse(tx_rdy);
      cyc(3);
      if (k == 0)
        pulse(gen_reset);
      else if (k == 1) begin
        ctl_reset = 1'b1;
        cyc(2);
        ctl_reset = 1'b0;
      end else begin
        powerup = 1'b0;
        cyc(2);
        powerup = 1'b1;
      end
      cyc(3);
      rd(16'h0000);
    end
    mask = 6'h00;
    for (k = 0; k < 16; k++) begin
      key = k[3:0];
      dtmf_ok = 1'b1;
      cyc(3);
      rd({12'h002, key_code(k)});
    end
    dtmf_ok = 1'b0;
    mask = 6'h20;
    ring_n = 1'b0;
    cyc(6);
    pin(1'b0);
    rd(16'hC000);
    ring_n = 1'b1;
    cyc(6);
    rd(16'h0000);
    mask = 6'h04;
    {cp_en, t2100, t2225} = 3'h7;
    cyc(3);
    rd(16'h84C0);
    {cp_en, t2100, t2225, pair} = 4'h1;
    cyc(3);
    rd(16'h0400);
    pair = 1'b0;
    mode = msi_pkg::MSI_RX_FSK;
    cyc(30);
    rx_en = 1'b1;
    sync_p = 1'b1;
    mask = 6'h01;
    pulse(rx_rdy);
    cyc(3);
    rd(16'h8640);
    pulse(rx_rd);
    cyc(3);
    rd(16'h0600);
    zu = 1'b1;
    {par1, par2, two, dbit} = 4'hF;
    pulse(dstb);
    pulse(frm);
    pulse(rx_ovf);
    cyc(3);
    rd(16'h873F);
    {zu, ou, hdlc, fcs} = 4'h7;
    cyc(3);
    rd(16'h06AB);
    pulse(rx_rd);
    {ou, par1, par2, two, hdlc, fcs, dbit} = '0;
    pulse(dstb);
    {rx_en, sync_p, mask} = '0;
    mode = msi_pkg::MSI_RX_MANUAL;
    descr_en = 1'b1;
    cyc(30);
    os = 1'b1;
    cyc(3);
    rd(16'h0180);
    ou = 1'b1;
    cyc(3);
    rd(16'h0080);
    {os, ou} = '0;
    mode = msi_pkg::MSI_RX_QAM_AUTO;
    cyc(30);
    pulse(qam_evt);
    cyc(3);
    rd(16'h0200);
    pulse(qam_rd);
    cyc(3);
    rd(16'h0000);
    pulse(brk);
    cyc(3);
    rd(16'h0100);
    rd(16'h0000);
    complete_run();
  end
endmodule
